// ===== ofp_pkg.sv
package ofp_pkg;

    // ------------------------------------------------------------------
    // Register numbers
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CMD       = 8'h02;
    localparam logic [7:0] REG_PW_BASE   = 8'h04;
    localparam logic [7:0] REG_PERIOD    = 8'h0C;
    localparam logic [7:0] REG_DIT_RATE  = 8'h1A;
    localparam logic [7:0] REG_DIT_SWING = 8'h1C;
    localparam logic [7:0] REG_STATUS    = 8'h1E;
    localparam logic [7:0] REG_FS_MODE   = 8'h20;
    localparam logic [7:0] REG_RUN_REQ   = 8'h22;
    localparam logic [7:0] REG_FS_PAT    = 8'h24;

    // ------------------------------------------------------------------
    // Fields, values and reset values
    // ------------------------------------------------------------------
    localparam int         RUN_BIT       = 0;
    localparam logic [7:0] MODE_STATIC   = 8'h00;
    localparam logic [7:0] RST_BYTE      = 8'h00;
    localparam logic [15:0] RST_WORD     = 16'h0000;
    localparam logic [15:0] PERIOD_MIN   = 16'h03E8;
    localparam logic [14:0] PW_FULL      = 15'h7FFF;
    localparam logic [7:0] SWING_MAX     = 8'h19;
    localparam logic [7:0] RATE_MAX      = 8'hFA;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int CLK_HZ        = 40000000;
    localparam int US_NS         = 1000;
    localparam int CYC_PER_US    = US_NS / CLK_PERIOD_NS;
    localparam int MON_SETTLE_US = 10;
    localparam int MIN_BUS_CYCLE_US = 250;

endpackage : ofp_pkg

// ===== ofp_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module ofp_ctrl
(
    // Clock, reset and enable
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        ce,
    // Register port from the bus controller
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rd_ack,
    // Network events and configuration
    input  wire logic        comm_lost,
    input  wire logic        sync_point,
    input  wire logic        fm_pwm,
    // Channel sense pins
    input  wire logic [3:0]  sense_level,
    input  wire logic [3:0]  overload,
    input  wire logic        io_supply_ok,
    // Channel drive and reporting
    output logic      [3:0]  ch_drive,
    output logic             err_msg,
    output logic      [3:0]  err_status,
    output logic             failsafe_active
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [14:0] dither_delta(input logic [7:0] swing);
        logic [22:0] p;
        p = 23'(swing) * 23'(ofp_pkg::PW_FULL);
        return 15'(p / 23'd200);
    endfunction : dither_delta

    function automatic logic is_on(input logic [15:0] us, input logic [16:0] pw,
                                   input logic [15:0] per);
        logic [31:0] lhs;
        logic [31:0] rhs;
        lhs = 32'(us) * 32'(ofp_pkg::PW_FULL);
        rhs = 32'(pw) * 32'(per);
        return lhs < rhs;
    endfunction : is_on

    localparam int ACC_W = 27;
    localparam logic [ACC_W-1:0] ACC_TOP = ACC_W'(ofp_pkg::CLK_HZ);
    localparam logic [5:0] US_LAST = 6'(ofp_pkg::CYC_PER_US - 1);
    localparam logic [3:0] SETTLE = 4'(ofp_pkg::MON_SETTLE_US);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [3:0]         s1_sense;
    logic [3:0]         s2_sense;
    logic [3:0]         s1_ovl;
    logic [3:0]         s2_ovl;
    logic               s1_sup;
    logic               s2_sup;

    logic [3:0]         cmd;
    logic [3:0]         hold_cmd;
    logic [3:0]         cmd_applied;
    logic [15:0]        pw [4];
    logic [15:0]        hold_pw [4];
    logic [15:0]        period;
    logic [7:0]         dit_rate;
    logic [7:0]         dit_swing;
    logic [7:0]         fs_mode;
    logic [7:0]         fs_pat;
    logic               run;
    logic               started;
    logic [5:0]         us_div;
    logic [15:0]        us_cnt;
    logic [ACC_W-1:0]   acc [4];
    logic [3:0]         dir;
    logic [3:0]         settle [4];
    logic [3:0]         mon;

    logic [3:0]         next_cmd;
    logic [3:0]         next_hold_cmd;
    logic [3:0]         next_cmd_applied;
    logic [15:0]        next_pw [4];
    logic [15:0]        next_hold_pw [4];
    logic [15:0]        next_period;
    logic [7:0]         next_dit_rate;
    logic [7:0]         next_dit_swing;
    logic [7:0]         next_fs_mode;
    logic [7:0]         next_fs_pat;
    logic               next_run;
    logic               next_started;
    logic [5:0]         next_us_div;
    logic [15:0]        next_us_cnt;
    logic [ACC_W-1:0]   next_acc [4];
    logic [3:0]         next_dir;
    logic [3:0]         next_settle [4];
    logic [3:0]         next_mon;
    logic [3:0]         next_ch_drive;
    logic [7:0]         next_reg_rdata;
    logic               next_reg_rd_ack;
    logic               next_err_msg;

    logic [15:0]        per_eff;
    logic               dit_glob;
    logic [14:0]        delta;
    logic [3:0]         pwm_on;
    logic [3:0]         target;
    logic               us_tick;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s1_sense <= 4'h0;
            s2_sense <= 4'h0;
            s1_ovl   <= 4'h0;
            s2_ovl   <= 4'h0;
            s1_sup   <= 1'b0;
            s2_sup   <= 1'b0;
        end
        else if (ce)
        begin
            s1_sense <= sense_level;
            s2_sense <= s1_sense;
            s1_ovl   <= overload;
            s2_ovl   <= s1_ovl;
            s1_sup   <= io_supply_ok;
            s2_sup   <= s1_sup;
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [16:0] w;
        logic [16:0] base;
        logic [7:0]  wbyte;
        w     = 17'h00000;
        base  = 17'h00000;
        wbyte = reg_wdata[7:0];

        next_cmd       = cmd;
        next_period    = period;
        next_dit_rate  = dit_rate;
        next_dit_swing = dit_swing;
        next_fs_mode   = fs_mode;
        next_fs_pat    = fs_pat;
        next_run       = run;
        next_started   = started;
        next_dir       = dir;
        for (int i = 0; i < 4; i++)
        begin
            next_pw[i] = pw[i];
        end

        if (reg_wr)
        begin
            case (reg_addr)
                ofp_pkg::REG_CMD:       next_cmd = wbyte[3:0];
                ofp_pkg::REG_PERIOD:    next_period = reg_wdata;
                ofp_pkg::REG_DIT_RATE:  next_dit_rate = wbyte;
                ofp_pkg::REG_DIT_SWING: next_dit_swing = wbyte;
                ofp_pkg::REG_FS_MODE:   next_fs_mode = wbyte;
                ofp_pkg::REG_FS_PAT:
                begin
                    if (run)
                    begin
                        next_fs_pat = wbyte;
                    end
                end
                ofp_pkg::REG_RUN_REQ:
                begin
                    // Reserved bits are not stored.
                    next_run = wbyte[ofp_pkg::RUN_BIT];
                    if (wbyte[ofp_pkg::RUN_BIT])
                    begin
                        next_started = 1'b1;
                    end
                end
                default:
                begin
                    for (int i = 0; i < 4; i++)
                    begin
                        if (reg_addr == ofp_pkg::REG_PW_BASE + 8'(2 * i))
                        begin
                            next_pw[i] = reg_wdata;
                            if (reg_wdata != pw[i])
                            begin
                                // Dither restarts towards the new setpoint.
                                next_dir[i] = $signed(reg_wdata) > $signed(pw[i]);
                            end
                        end
                    end
                end
            endcase
        end
        if (comm_lost)
        begin
            next_run = 1'b0;
        end

        // Hold copies track only what was accepted while running.
        next_hold_cmd = run ? cmd : hold_cmd;
        for (int i = 0; i < 4; i++)
        begin
            next_hold_pw[i] = run ? pw[i] : hold_pw[i];
        end
        next_cmd_applied = sync_point ? (run ? cmd : hold_cmd) : cmd_applied;

        // Microsecond timebase and PWM period counter.
        us_tick     = (us_div == US_LAST);
        next_us_div = us_tick ? 6'h00 : us_div + 6'h01;
        per_eff     = (period < ofp_pkg::PERIOD_MIN) ? ofp_pkg::PERIOD_MIN : period;
        next_us_cnt = us_cnt;
        if (period == ofp_pkg::RST_WORD)
        begin
            next_us_cnt = 16'h0000;
        end
        else if (us_tick)
        begin
            next_us_cnt = (us_cnt >= per_eff - 16'h0001) ? 16'h0000 : us_cnt + 16'h0001;
        end

        // Dither is one global switch; width range gates each channel.
        dit_glob = (dit_swing != 8'h00) && (dit_rate != 8'h00);
        delta = dither_delta((dit_swing > ofp_pkg::SWING_MAX) ? ofp_pkg::SWING_MAX
                                                              : dit_swing);
        for (int i = 0; i < 4; i++)
        begin
            base = {hold_pw[i][15], hold_pw[i]};
            if (run)
            begin
                base = {pw[i][15], pw[i]};
            end
            next_acc[i] = acc[i];
            if (dit_glob)
            begin
                next_acc[i] = acc[i] + ACC_W'(2 * ((dit_rate > ofp_pkg::RATE_MAX)
                                                   ? ofp_pkg::RATE_MAX : dit_rate));
                if (next_acc[i] >= ACC_TOP)
                begin
                    next_acc[i] = next_acc[i] - ACC_TOP;
                    next_dir[i] = ~next_dir[i];
                end
            end
            if (reg_wr && reg_addr == ofp_pkg::REG_PW_BASE + 8'(2 * i)
                && reg_wdata != pw[i])
            begin
                next_acc[i] = '0;
            end
            w = base;
            if (dit_glob && !base[16] && base != 17'h0 && base < 17'(ofp_pkg::PW_FULL))
            begin
                w = dir[i] ? base + 17'(delta) : base - 17'(delta);
                if (w[16])
                begin
                    w = 17'h00000;
                end
                else if (w > 17'(ofp_pkg::PW_FULL))
                begin
                    w = 17'(ofp_pkg::PW_FULL);
                end
            end
            if (period == ofp_pkg::RST_WORD || base[16] || w == 17'h0)
            begin
                pwm_on[i] = 1'b0;
            end
            else if (w >= 17'(ofp_pkg::PW_FULL))
            begin
                pwm_on[i] = 1'b1;
            end
            else
            begin
                pwm_on[i] = is_on(us_cnt, w, per_eff);
            end
        end

        target = fm_pwm ? pwm_on : cmd_applied;
        if (!started)
        begin
            next_ch_drive = 4'h0;
        end
        else if (run || fs_mode != ofp_pkg::MODE_STATIC)
        begin
            next_ch_drive = target;
        end
        else
        begin
            next_ch_drive = fs_pat[3:0];
        end

        // Monitoring: compare sensed level with the driver command.
        for (int i = 0; i < 4; i++)
        begin
            next_settle[i] = settle[i];
            next_mon[i]    = mon[i];
            if (next_ch_drive[i] != ch_drive[i])
            begin
                next_settle[i] = SETTLE;
                next_mon[i]    = 1'b0;
            end
            else if (settle[i] != 4'h0)
            begin
                if (us_tick)
                begin
                    next_settle[i] = settle[i] - 4'h1;
                end
            end
            else
            begin
                next_mon[i] = s2_ovl[i] || (s2_sense[i] != ch_drive[i])
                              || (ch_drive[i] && !s2_sup);
            end
        end
        next_err_msg = (next_mon != mon);

        next_reg_rd_ack = reg_rd;
        case (reg_addr)
            ofp_pkg::REG_STATUS:  next_reg_rdata = {4'h0, mon};
            ofp_pkg::REG_FS_MODE: next_reg_rdata = fs_mode;
            ofp_pkg::REG_FS_PAT:  next_reg_rdata = fs_pat;
            default:              next_reg_rdata = ofp_pkg::RST_BYTE;
        endcase
        if (!reg_rd)
        begin
            next_reg_rdata = reg_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cmd             <= 4'h0;
            hold_cmd        <= 4'h0;
            cmd_applied     <= 4'h0;
            period          <= ofp_pkg::RST_WORD;
            dit_rate        <= ofp_pkg::RST_BYTE;
            dit_swing       <= ofp_pkg::RST_BYTE;
            fs_mode         <= ofp_pkg::RST_BYTE;
            fs_pat          <= ofp_pkg::RST_BYTE;
            run             <= 1'b0;
            started         <= 1'b0;
            us_div          <= 6'h00;
            us_cnt          <= 16'h0000;
            dir             <= 4'h0;
            mon             <= 4'h0;
            ch_drive        <= 4'h0;
            reg_rdata       <= ofp_pkg::RST_BYTE;
            reg_rd_ack      <= 1'b0;
            err_msg         <= 1'b0;
            err_status      <= 4'h0;
            failsafe_active <= 1'b1;
            for (int i = 0; i < 4; i++)
            begin
                pw[i]      <= ofp_pkg::RST_WORD;
                hold_pw[i] <= ofp_pkg::RST_WORD;
                acc[i]     <= '0;
                settle[i]  <= 4'h0;
            end
        end
        else if (ce)
        begin
            cmd             <= next_cmd;
            hold_cmd        <= next_hold_cmd;
            cmd_applied     <= next_cmd_applied;
            period          <= next_period;
            dit_rate        <= next_dit_rate;
            dit_swing       <= next_dit_swing;
            fs_mode         <= next_fs_mode;
            fs_pat          <= next_fs_pat;
            run             <= next_run;
            started         <= next_started;
            us_div          <= next_us_div;
            us_cnt          <= next_us_cnt;
            dir             <= next_dir;
            mon             <= next_mon;
            ch_drive        <= next_ch_drive;
            reg_rdata       <= next_reg_rdata;
            reg_rd_ack      <= next_reg_rd_ack;
            err_msg         <= next_err_msg;
            err_status      <= next_mon;
            failsafe_active <= !next_run;
            for (int i = 0; i < 4; i++)
            begin
                pw[i]      <= next_pw[i];
                hold_pw[i] <= next_hold_pw[i];
                acc[i]     <= next_acc[i];
                settle[i]  <= next_settle[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_lost_clears_run;
        @(posedge clk) disable iff (reset) (ce && comm_lost) |=> failsafe_active;
    endproperty
    a_lost_clears_run: assert property (p_lost_clears_run)
        else $error("run bit survived a fail-safe event");

    property p_off_before_start;
        @(posedge clk) disable iff (reset) (ce && !started && !next_started) |=> ch_drive == 4'h0;
    endproperty
    a_off_before_start: assert property (p_off_before_start)
        else $error("channel driven before run request");

    property p_static_pattern;
        @(posedge clk) disable iff (reset)
            (ce && started && !run && fs_mode == ofp_pkg::MODE_STATIC) |=> ch_drive == $past(fs_pat[3:0]);
    endproperty
    a_static_pattern: assert property (p_static_pattern)
        else $error("static fail-safe pattern not driven");

    property p_pat_locked;
        @(posedge clk) disable iff (reset) (ce && !run && !comm_lost) ##1 (ce && !run) |-> $stable(fs_pat);
    endproperty
    a_pat_locked: assert property (p_pat_locked)
        else $error("pattern changed while run bit clear");

    property p_err_msg;
        @(posedge clk) disable iff (reset) ce ##1 (ce && $changed(err_status)) |-> err_msg;
    endproperty
    a_err_msg: assert property (p_err_msg)
        else $error("status change without error message");

    property p_pwm_zero_off;
        @(posedge clk) disable iff (reset)
            (ce && fm_pwm && run && period == ofp_pkg::RST_WORD) |=> ch_drive == 4'h0;
    endproperty
    a_pwm_zero_off: assert property (p_pwm_zero_off)
        else $error("pwm output on with zero period");

    property p_restart_clears;
        @(posedge clk) disable iff (reset)
            (ce && next_ch_drive[0] != ch_drive[0]) |=> !err_status[0] [*2];
    endproperty
    a_restart_clears: assert property (p_restart_clears)
        else $error("monitoring not restarted on output change");

    property p_rd_ack;
        @(posedge clk) disable iff (reset)
            (ce && reg_rd && reg_addr == ofp_pkg::REG_STATUS)
            |=> reg_rd_ack && reg_rdata == {4'h0, $past(mon)};
    endproperty
    a_rd_ack: assert property (p_rd_ack)
        else $error("status read returned wrong value");

    property p_resume;
        @(posedge clk) disable iff (reset)
            (ce && reg_wr && reg_addr == ofp_pkg::REG_RUN_REQ && reg_wdata[0] && !comm_lost)
            |=> !failsafe_active;
    endproperty
    a_resume: assert property (p_resume)
        else $error("set run bit did not resume normal output");

endmodule : ofp_ctrl

`default_nettype wire

// ===== ofp_master.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// Master side of the register port.
// ------
module ofp_master
(
    // Clock and read return
    input  wire logic        clk,
    input  wire logic [7:0]  reg_rdata,
    input  wire logic        reg_rd_ack,
    // Requests and network events
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [7:0]  reg_addr,
    output logic      [15:0] reg_wdata,
    output logic             comm_lost,
    output logic             sync_point
);
    // A sync point stands for one bus cycle, so two never come closer than the shortest cycle.
    localparam int GAP_NS    = ofp_pkg::MIN_BUS_CYCLE_US * ofp_pkg::US_NS;
    time           last_sync = 0;
    logic          synced    = 1'b0;

    initial
    begin
        {reg_wr, reg_rd, comm_lost, sync_point} = 4'h0;
        reg_addr  = 8'h00;
        reg_wdata = 16'h0000;
    end

    // Data is inverted once released so a stale word never looks valid.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk) #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge clk) #1;
        reg_wr    = 1'b0;
        reg_wdata = ~d;
    endtask : wr

    // The request stands until the edge that sees the acknowledge; a repeated read is harmless.
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk) #1;
        reg_addr = a;
        reg_rd   = 1'b1;
        repeat (2) @(posedge clk);
        q = (reg_rd_ack === 1'b1) ? reg_rdata : 8'hEE;
        #1;
        reg_rd = 1'b0;
    endtask : rd

    task automatic pulse(input logic lost);
        while (!lost && synced && ($time - last_sync) < GAP_NS)
            @(posedge clk);
        @(posedge clk) #1;
        comm_lost  = lost;
        sync_point = ~lost;
        @(posedge clk) #1;
        comm_lost  = 1'b0;
        sync_point = 1'b0;
        if (!lost)
        begin
            last_sync = $time;
            synced    = 1'b1;
        end
    endtask : pulse

    task automatic go;
        wr(ofp_pkg::REG_RUN_REQ, 16'h0001);
    endtask : go
endmodule : ofp_master
`default_nettype wire

// ===== output_failsafe_pwm_controller_test.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// Register-level tests.
// ------
module output_failsafe_pwm_controller_test;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        fm_pwm = 1'b0;
    logic [3:0]  overload = 4'h0;
    logic        ce = 1'b1;
    logic        sup = 1'b1;
    logic        reg_wr, reg_rd, reg_rd_ack, comm_lost, sync_point, err_msg, fs_on;
    logic [7:0]  reg_addr, reg_rdata, q;
    logic [15:0] reg_wdata;
    logic [3:0]  ch_drive, err_status;
    int          err_total = 0, cmp_count = 0, msgs = 0, m0, on1, on4;

    always #12.5 clk = ~clk;
    always @(posedge clk)
        msgs <= msgs + int'(err_msg === 1'b1);

    ofp_master ofp_master_i
    (
        .clk(clk), .reg_rdata(reg_rdata), .reg_rd_ack(reg_rd_ack), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .comm_lost(comm_lost), .sync_point(sync_point)
    );
    // The load is ideal, so each sense pin simply follows its driver.
    ofp_ctrl ofp_ctrl_i
    (
        .clk(clk), .reset(reset), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rd_ack(reg_rd_ack), .comm_lost(comm_lost), .sync_point(sync_point),
        .fm_pwm(fm_pwm), .sense_level(ch_drive), .overload(overload),
        .io_supply_ok(sup), .ch_drive(ch_drive), .err_msg(err_msg),
        .err_status(err_status), .failsafe_active(fs_on)
    );

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic final_report;
        if (err_total == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt

    initial
    begin
        #2_400_000;
        err_total++;
        final_report();
    end

    initial
    begin
        wt(6);
        reset = 1'b0;
        chk({7'h00, fs_on}, 8'h01);
        ofp_master_i.wr(ofp_pkg::REG_CMD, 16'h000F);
        ofp_master_i.pulse(1'b0);
        wt(3);
        chk({4'h0, ch_drive}, 8'h00);
        ofp_master_i.wr(ofp_pkg::REG_FS_PAT, 16'h0005);
        ofp_master_i.go();
        wt(2);
        chk({7'h00, fs_on}, 8'h00);
        ofp_master_i.pulse(1'b0);
        wt(3);
        chk({4'h0, ch_drive}, 8'h0F);
        ofp_master_i.wr(ofp_pkg::REG_CMD, 16'h000A);
        wt(2);
        chk({4'h0, ch_drive}, 8'h0F);
        ofp_master_i.pulse(1'b0);
        wt(3);
        chk({4'h0, ch_drive}, 8'h0A);
        ofp_master_i.pulse(1'b1);
        wt(2);
        chk({7'h00, fs_on}, 8'h01);
        chk({4'h0, ch_drive}, 8'h00);
        ofp_master_i.go();
        ofp_master_i.wr(ofp_pkg::REG_FS_PAT, 16'h0005);
        ofp_master_i.wr(ofp_pkg::REG_CMD, 16'h0003);
        ofp_master_i.pulse(1'b1);
        ofp_master_i.pulse(1'b0);
        wt(3);
        chk({4'h0, ch_drive}, 8'h05);
        ofp_master_i.go();
        wt(2);
        chk({4'h0, ch_drive}, 8'h03);
        ofp_master_i.wr(ofp_pkg::REG_FS_MODE, 16'h0001);
        ofp_master_i.pulse(1'b1);
        wt(2);
        chk({4'h0, ch_drive}, 8'h03);
        ofp_master_i.go();
        m0 = msgs;
        overload = 4'h2;
        wt(800);
        ofp_master_i.rd(ofp_pkg::REG_STATUS, q);
        chk(q, 8'h02);
        ofp_master_i.wr(ofp_pkg::REG_CMD, 16'h0001);
        ofp_master_i.pulse(1'b0);
        wt(3);
        chk({4'h0, err_status}, 8'h00);
        overload = 4'h0;
        wt(800);
        chk(8'(msgs - m0), 8'h02);
        sup = 1'b0;
        wt(5);
        chk({4'h0, err_status}, 8'h01);
        sup = 1'b1;
        ce = 1'b0;
        ofp_master_i.wr(ofp_pkg::REG_FS_MODE, 16'h0000);
        ce = 1'b1;
        ofp_master_i.rd(ofp_pkg::REG_FS_MODE, q);
        chk(q, 8'h01);
        ofp_master_i.rd(8'hFE, q);
        chk(q, 8'h00);
        fm_pwm = 1'b1;
        ofp_master_i.wr(ofp_pkg::REG_PW_BASE, 16'h4000);
        ofp_master_i.wr(ofp_pkg::REG_PW_BASE + 8'h06, 16'h7FFF);
        ofp_master_i.wr(ofp_pkg::REG_PERIOD, ofp_pkg::PERIOD_MIN);
        wt(100);
        on1 = 0;
        on4 = 0;
        repeat (40000)
        begin
            @(posedge clk);
            on1 += int'(ch_drive[0] === 1'b1);
            on4 += int'(ch_drive[3] === 1'b1);
        end
        // One microsecond of slack below 20000 cycles and two above cover how the period counter rounds.
        chk(8'(on1 > 19960 && on1 < 20080), 8'h01);
        chk(8'(on4 == 40000), 8'h01);
        ofp_master_i.wr(ofp_pkg::REG_PERIOD, 16'h0000);
        wt(80);
        chk({4'h0, ch_drive}, 8'h00);
        final_report();
    end
endmodule : output_failsafe_pwm_controller_test
`default_nettype wire
